// ==== design/pdv_pkg.sv ====
// Shared constants and carrier types for the programmable integer divider
package pdv_pkg;

  // Width of the modulus bus, top bit is the most significant
  localparam int unsigned RATIO_W = 9;
  // Width of a pulse-width value (largest width is 128)
  localparam int unsigned WIDTH_W = RATIO_W - 1;

  // Legal division ratio range
  localparam logic [RATIO_W-1:0] MIN_RATIO = 9'h008;
  localparam logic [RATIO_W-1:0] MAX_RATIO = 9'h1FF;
  // Split inside the small-ratio range and the first octave band
  localparam logic [RATIO_W-1:0] SMALL_SPLIT = 9'h00C;
  localparam logic [RATIO_W-1:0] BAND_START = 9'h010;
  // Offsets subtracted from small ratios to get the high time
  localparam logic [RATIO_W-1:0] SMALL_OFF_LO = 9'h004;
  localparam logic [RATIO_W-1:0] SMALL_OFF_HI = 9'h008;

  // Values after reset
  localparam logic [RATIO_W-1:0] RST_CNT = 9'h000;
  localparam logic [RATIO_W-1:0] RST_RATIO = 9'h008;
  localparam logic [WIDTH_W-1:0] RST_WIDTH = 8'h04;

  // Modulus lines as they arrive: level of each line and whether it is driven
  typedef struct packed {
    logic [RATIO_W-1:0] level;
    logic [RATIO_W-1:0] driven;
  } pdv_mod_t;

  // Whole state of the divider
  typedef struct packed {
    logic run;
    logic start;
    logic out;
    logic [RATIO_W-1:0] cnt;
    logic [RATIO_W-1:0] ratio;
    logic [WIDTH_W-1:0] width;
  } pdv_state_t;

endpackage : pdv_pkg

// ==== design/pdv_pulse_width.sv ====
// Lookup of the output high time, in input cycles, for a division ratio
`timescale 1ns/1ps
`default_nettype none
module pdv_pulse_width #(
  parameter int unsigned RATIO_W = 9
) (
  input wire logic [RATIO_W-1:0] ratio_i,
  output logic [RATIO_W-2:0] width_o
);
  import pdv_pkg::*;

  // The band logic assumes at least the small range plus one octave
  if (RATIO_W < 5 || RATIO_W > 16) begin : g_bad_width
    $error("pdv_pulse_width: RATIO_W out of range");
  end

  logic [RATIO_W-2:0] band [4:RATIO_W];
  logic [RATIO_W-1:0] small_w;

  // Octave band width
  // Highest set bit wins: band width is half the band's lowest ratio
  assign band[4] = '0;
  for (genvar i = 4; i < RATIO_W; i++) begin : g_band
    assign band[i+1] = ratio_i[i] ? (RATIO_W-1)'(1 << (i - 1)) : band[i];
  end

  // Small-ratio width
  // Small ratios: high time moves with the ratio
  always_comb begin
    if (ratio_i >= SMALL_SPLIT) begin
      small_w = ratio_i - SMALL_OFF_HI;
    end else begin
      small_w = ratio_i - SMALL_OFF_LO;
    end
  end

  // Choose between small-range and octave-band width
  assign width_o = (ratio_i < BAND_START) ? small_w[RATIO_W-2:0] : band[RATIO_W];

endmodule : pdv_pulse_width
`default_nettype wire

// ==== design/pdv_divider.sv ====
// Programmable integer divider: one output period every N input cycles
//
// What this block does
// - Modulus lines form unsigned ratio 8 to 511
// - Undriven modulus lines count as zero bits
// - Ratios 8-15: high time N-4 or N-8
// - Ratios 16-511: high time half band start
// - Ratio captured once per output period
`timescale 1ns/1ps
`default_nettype none
module pdv_divider (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire pdv_pkg::pdv_mod_t modulus_select_lines_i,
  output var logic div_out_o,
  output var logic period_start_o,
  output var logic [pdv_pkg::RATIO_W-1:0] active_ratio_o
);
  import pdv_pkg::*;

  pdv_state_t state_reg;
  pdv_state_t state_next;
  logic [RATIO_W-1:0] masked_ratio;
  logic [RATIO_W-1:0] eff_ratio;
  logic [WIDTH_W-1:0] eff_width;
  logic capture;

  for (genvar i = 0; i < RATIO_W; i++) begin : g_mask
    assign masked_ratio[i] = modulus_select_lines_i.level[i] & modulus_select_lines_i.driven[i];
  end

  // Unsigned ratio, clamped
  // Ratios below the legal floor run as the floor so the counter never stalls
  assign eff_ratio = (masked_ratio < MIN_RATIO) ? MIN_RATIO : masked_ratio;

  // High time for the ratio about to be captured
  pdv_pulse_width #(
    .RATIO_W(RATIO_W)
  ) u_width (
    .ratio_i(eff_ratio),
    .width_o(eff_width)
  );

  // Capture at period boundary
  // The lines are looked at only here, so mid-period changes cannot tear a period
  assign capture = !state_reg.run || (state_reg.cnt == state_reg.ratio - 9'h001);

  // Next-state logic of the whole divider
  always_comb begin
    state_next = state_reg;
    state_next.run = 1'b1;
    state_next.start = capture;
    if (capture) begin
      state_next.cnt = RST_CNT;
      state_next.ratio = eff_ratio;
      state_next.width = eff_width;
      state_next.out = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 9'h001;
      state_next.out = (state_next.cnt < {1'b0, state_reg.width});
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '{run: 1'b0, start: 1'b0, out: 1'b0, cnt: RST_CNT,
                     ratio: RST_RATIO, width: RST_WIDTH};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign div_out_o = state_reg.out;
  assign period_start_o = state_reg.start;
  assign active_ratio_o = state_reg.ratio;

  // Helper: cycles since the last period start, and whether a period start has been seen
  logic [RATIO_W:0] gap_cnt;
  logic seen_start;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt <= '0;
      seen_start <= 1'b0;
    end else begin
      if (period_start_o) begin
        gap_cnt <= 10'h001;
        seen_start <= 1'b1;
      end else begin
        gap_cnt <= gap_cnt + 10'h001;
      end
    end
  end

  // Helper: expected clamp of the masked lines, kept apart from the datapath
  logic [RATIO_W-1:0] chk_ratio;
  assign chk_ratio = (masked_ratio >= MIN_RATIO) ? masked_ratio : MIN_RATIO;

  // Helper: high time of the running period from the band table, apart from the lookup
  logic [RATIO_W-1:0] chk_width;
  always_comb begin
    if (active_ratio_o >= 9'h100) begin
      chk_width = 9'h080;
    end else if (active_ratio_o >= 9'h080) begin
      chk_width = 9'h040;
    end else if (active_ratio_o >= 9'h040) begin
      chk_width = 9'h020;
    end else if (active_ratio_o >= 9'h020) begin
      chk_width = 9'h010;
    end else if (active_ratio_o >= BAND_START) begin
      chk_width = 9'h008;
    end else if (active_ratio_o >= SMALL_SPLIT) begin
      chk_width = active_ratio_o - SMALL_OFF_HI;
    end else begin
      chk_width = active_ratio_o - SMALL_OFF_LO;
    end
  end

  // Ratio in use always lies inside the legal range
  a_ratio_in_range: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    state_reg.run |-> (active_ratio_o >= MIN_RATIO && active_ratio_o <= MAX_RATIO))
    else $error("active ratio outside 8..511");

  // Captured ratio equals the clamped masked lines of the capture cycle
  a_ratio_captured: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o |-> active_ratio_o == $past(chk_ratio))
    else $error("captured ratio differs from masked modulus lines");

  // All lines undriven must give the floor ratio
  a_undriven_floor: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (capture && modulus_select_lines_i.driven == '0) |=> active_ratio_o == MIN_RATIO)
    else $error("undriven modulus lines did not read as zero");

  // Small ratios 8 to 11 hold high for N minus 4
  a_small_low_width: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && active_ratio_o < SMALL_SPLIT)
    |-> state_reg.width == WIDTH_W'(active_ratio_o - SMALL_OFF_LO))
    else $error("high time wrong for ratio 8..11");

  // Small ratios 12 to 15 hold high for N minus 8
  a_small_high_width: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && active_ratio_o >= SMALL_SPLIT && active_ratio_o < BAND_START)
    |-> state_reg.width == WIDTH_W'(active_ratio_o - SMALL_OFF_HI))
    else $error("high time wrong for ratio 12..15");

  // Ratio 9 gives exactly five high cycles then low
  a_ratio9_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && active_ratio_o == 9'h009) |-> div_out_o [*5] ##1 !div_out_o)
    else $error("ratio 9 pulse not five cycles");

  // First octave band holds high for eight cycles
  a_band16_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && active_ratio_o >= 9'h010 && active_ratio_o < 9'h020)
    |-> div_out_o [*8] ##1 !div_out_o)
    else $error("band 16..31 pulse not eight cycles");

  // Top band width is 128 cycles
  a_band256_width: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && active_ratio_o[8]) |-> state_reg.width == 8'h80)
    else $error("band 256..511 width not 128");

  // Ratio may change only at the opening of a period
  a_ratio_once: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_reg.run && !$stable(active_ratio_o)) |-> period_start_o)
    else $error("ratio changed inside an output period");

  // Each period lasts exactly the ratio it captured
  a_period_length: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (period_start_o && seen_start) |-> gap_cnt == {1'b0, $past(active_ratio_o)})
    else $error("output period length differs from its ratio");

  // Every period opens on a high output
  a_start_high: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o |-> $rose(div_out_o))
    else $error("period did not open on a rising edge");

  // The start marker lasts exactly one input cycle
  a_start_single: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o |=> !period_start_o)
    else $error("period start marker held longer than one cycle");

  // Output is high exactly while the count is below the width
  a_high_window: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    state_reg.run |-> div_out_o == (period_start_o || gap_cnt < {1'b0, chk_width}))
    else $error("output level disagrees with position in period");

  // Main scenarios
  c_ratio_min: cover property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o && active_ratio_o == MIN_RATIO);

  c_ratio_max: cover property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o && active_ratio_o == MAX_RATIO);

  c_ratio_hop: cover property (
    @(posedge clk_i) disable iff (!rst_b_i)
    period_start_o && seen_start && active_ratio_o != $past(active_ratio_o));

  c_undriven: cover property (
    @(posedge clk_i) disable iff (!rst_b_i)
    capture && modulus_select_lines_i.driven != '1 && modulus_select_lines_i.driven != '0);

  c_all_undriven: cover property (
    @(posedge clk_i) disable iff (!rst_b_i)
    capture && modulus_select_lines_i.driven == '0);

endmodule : pdv_divider
`default_nettype wire

// ==== dv/pdv_ctrl_model.sv ====
// Modulus controller model clocked by the divider output
`timescale 1ns/1ps
`default_nettype none
module pdv_ctrl_model (
  input wire logic div_clk_i,
  input wire logic [8:0] req_ratio_i,
  input wire logic [8:0] req_mask_i,
  output var pdv_pkg::pdv_mod_t lines_o
);
  import pdv_pkg::*;
  // Lines start at the smallest ratio, all driven
  initial lines_o = '{level: MIN_RATIO, driven: 9'h1FF};
  // one update per period
  // Request taken at the rising edge, lines move 1 ns later and sit still a whole period
  always @(posedge div_clk_i) begin
    lines_o.driven <= #1 req_mask_i;
    // Undriven lines show the inverse of their last level
    lines_o.level <= #1 (req_ratio_i & req_mask_i) | (~req_mask_i & ~lines_o.level);
  end
endmodule : pdv_ctrl_model
`default_nettype wire

// ==== dv/test_programmable_integer_divider.sv ====
// Self-checking testbench of the programmable integer divider
`timescale 1ns/1ps
`default_nettype none
module test_programmable_integer_divider;
  import pdv_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [8:0] req_ratio = 9'h008;
  logic [8:0] req_mask = 9'h1FF;
  pdv_mod_t lines;
  logic div_out;
  logic period_start;
  logic [8:0] active_ratio;
  int err_total = 0;
  int checked = 0;
  // Input clock, 8 ns period
  always #4 clk_i = ~clk_i;
  pdv_divider dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .modulus_select_lines_i(lines),
    .div_out_o(div_out), .period_start_o(period_start), .active_ratio_o(active_ratio));
  pdv_ctrl_model ctrl_u (.div_clk_i(div_out), .req_ratio_i(req_ratio),
    .req_mask_i(req_mask), .lines_o(lines));

  task automatic summarize();
    $display("mismatches %0d, checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : cmp

  // Steps to the next period start, bounded
  task automatic next_start();
    for (int i = 0; i < 600; i++) begin
      @(posedge clk_i);
      #1;
      if (period_start === 1'b1) return;
    end
    err_total++;
    $display("unexpected at %0t: no period start", $time);
    summarize();
  endtask : next_start

  // High time worked out from the ratio
  function automatic logic [9:0] exp_w(input logic [9:0] n);
    logic [9:0] w;
    w = (n < 10'h00C) ? n - 10'h004 : n - 10'h008;
    for (int k = 4; k < 9; k++) if (n >= (10'h001 << k)) w = 10'h001 << (k - 1);
    return w;
  endfunction : exp_w

  // Requests a ratio, then measures the period that runs with it
  task automatic run_ratio(input logic [8:0] req, input logic [8:0] mask, input logic [9:0] n);
    logic [9:0] hi;
    logic [9:0] len;
    req_ratio = req;
    req_mask = mask;
    hi = 10'h000;
    len = 10'h000;
    next_start();
    next_start();
    cmp({1'b0, active_ratio}, n, "ratio");
    do begin
      // High cycles count only while they lead the period
      if (div_out === 1'b1) hi = (len == hi) ? hi + 10'h001 : 10'h3FF;
      len++;
      @(posedge clk_i);
      #1;
    end while (period_start !== 1'b1 && len < 10'h258);
    cmp(len, n, "period");
    cmp(hi, exp_w(n), "high");
    // A period that never closed has been counted above; stop the run
    if (len == 10'h258) summarize();
  endtask : run_ratio

  // Every small ratio and both ends of each band, back to back
  task automatic t_widths();
    logic [8:0] tbl[22] = '{9'h008, 9'h009, 9'h00A, 9'h00B, 9'h00C, 9'h00D, 9'h00E, 9'h00F,
      9'h010, 9'h01F, 9'h020, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h1FF,
      9'h009, 9'h008, 9'h011, 9'h008};
    foreach (tbl[i]) run_ratio(tbl[i], 9'h1FF, {1'b0, tbl[i]});
  endtask : t_widths

  // Undriven lines read as zero, small results run as the minimum
  task automatic t_undriven();
    run_ratio(9'h1FF, 9'h00D, 10'h00D);
    run_ratio(9'h1FF, 9'h003, 10'h008);
    run_ratio(9'h1FF, 9'h000, 10'h008);
    run_ratio(9'h1FF, 9'h100, 10'h100);
  endtask : t_undriven

  // Reset in mid period, then a fresh period at the first edge
  task automatic t_reset();
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b0;
    #1;
    cmp({9'h000, div_out}, 10'h000, "rst out");
    cmp({9'h000, period_start}, 10'h000, "rst start");
    cmp({1'b0, active_ratio}, {1'b0, RST_RATIO}, "rst ratio");
    repeat (2) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    @(posedge clk_i);
    #1;
    cmp({8'h00, div_out, period_start}, 10'h003, "first period");
    cmp({1'b0, active_ratio}, 10'h100, "first ratio");
  endtask : t_reset

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    t_widths();
    t_undriven();
    t_reset();
    run_ratio(9'h00B, 9'h1FF, 10'h00B);
    summarize();
  end
endmodule : test_programmable_integer_divider
`default_nettype wire
